// file: rtl/error_check_enable_register.sv
// Notes on behaviour
// - The enable register sits at address 0x07 and resets to 0x0040.
// - Bits 11, 10, 9 and 3 each gate one flag, which rises only while enabled.
// - Bit 12 runs the clock counter, resets to 0; count is readable.
// - Bit 11 lets the positive input range fault set its flag, resets to 0.
// - Bit 10 lets the negative input range fault set its flag, resets to 0.
// - Bit 9 lets the reference range fault set its flag, resets to 0.
// - Bit 3 lets the missing reference fault set its flag, resets to 0.
// - Bits 15 to 13 are reserved, read-only and read as zero.
// - Writing 1 to a flag clears it unless its enabled fault is present in that cycle; writing 0 leaves it unchanged.
`timescale 1ns/1ps
`include "errchk_cfg.svh"

module error_check_enable_register
    import errchk_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Decoded register port from the serial interface
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [`REG_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Fault conditions from the analog monitors
    input wire logic positive_analog_input_fault,
    input wire logic negative_analog_input_fault,
    input wire logic external_reference_input_fault,
    input wire logic external_reference_input_missing,
    // Status
    output logic [`REG_DATA_W-1:0] error_flag_enable,
    output logic [`FLAG_COUNT-1:0] error_flags,
    output logic [`CLOCK_COUNT_W-1:0] clock_count
);

    reg_word_type enable_q, enable_d;
    flag_vec_type flag_q, flag_d;
    flag_vec_type fault_in;
    flag_vec_type gate;
    flag_vec_type clear;
    reg_word_type rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic write_enable_reg;
    logic write_flag_reg;
    logic master_clock_counter_on;
    logic positive_input_range_check_on;
    logic negative_input_range_check_on;
    logic reference_range_check_on;
    logic reference_detect_check_on;

    // Address decode
    assign write_enable_reg = reg_write && reg_addr == `ADDR_ERROR_ENABLE;
    assign write_flag_reg = reg_write && reg_addr == `ADDR_ERROR_FLAGS;

    assign master_clock_counter_on = enable_q[`BIT_MASTER_CLOCK_COUNTER_ON];
    assign positive_input_range_check_on =
        enable_q[`BIT_POSITIVE_INPUT_RANGE_CHECK_ON];
    assign negative_input_range_check_on =
        enable_q[`BIT_NEGATIVE_INPUT_RANGE_CHECK_ON];
    assign reference_range_check_on =
        enable_q[`BIT_REFERENCE_RANGE_CHECK_ON];
    assign reference_detect_check_on =
        enable_q[`BIT_REFERENCE_DETECT_CHECK_ON];

    always_comb
    begin
        enable_d = enable_q;
        if (write_enable_reg)
        begin
            enable_d = reg_wdata & ~`ENABLE_RSV_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            enable_q <= `ENABLE_RESET;
        end
        else
        begin
            enable_q <= enable_d;
        end
    end

    // gates from stored enables
    // A write therefore acts a cycle later, never in its own cycle
    assign fault_in[`FLAG_POSITIVE_INPUT_RANGE] = positive_analog_input_fault;
    assign fault_in[`FLAG_NEGATIVE_INPUT_RANGE] = negative_analog_input_fault;
    assign fault_in[`FLAG_REFERENCE_RANGE] = external_reference_input_fault;
    assign fault_in[`FLAG_REFERENCE_MISSING] =
        external_reference_input_missing;
    assign gate[`FLAG_POSITIVE_INPUT_RANGE] = positive_input_range_check_on;
    assign gate[`FLAG_NEGATIVE_INPUT_RANGE] = negative_input_range_check_on;
    assign gate[`FLAG_REFERENCE_RANGE] = reference_range_check_on;
    assign gate[`FLAG_REFERENCE_MISSING] = reference_detect_check_on;

    genvar i;
    generate
        for (i = 0; i < `FLAG_COUNT; i++)
        begin : g_flag
            assign clear[i] = write_flag_reg && reg_wdata[i];
            // set only when enabled, and set wins over clear
            assign flag_d[i] = (fault_in[i] && gate[i]) ||
                (flag_q[i] && !clear[i]);
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    master_clock_counter #(
        .WIDTH(`CLOCK_COUNT_W)
    ) u_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .count_on(master_clock_counter_on),
        .count_q(clock_count)
    );

    // Read path; unmapped addresses return zero
    always_comb
    begin
        rdata_d = rdata_q;
        rvalid_d = reg_read;
        if (reg_read)
        begin
            case (reg_addr)
                `ADDR_ERROR_ENABLE: rdata_d = enable_q;
                `ADDR_ERROR_FLAGS:
                    rdata_d = {{(`REG_DATA_W-`FLAG_COUNT){1'b0}}, flag_q};
                `ADDR_CLOCK_COUNT: rdata_d = clock_count;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign error_flag_enable = enable_q;
    assign error_flags = flag_q;

    chk_enable_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        write_enable_reg |=>
        enable_q == ($past(reg_wdata) & ~`ENABLE_RSV_MASK))
        else $error("enable register did not take the write");

    chk_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        (enable_q & `ENABLE_RSV_MASK) == 16'h0000)
        else $error("reserved enable bits not zero");

    chk_positive_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(flag_q[`FLAG_POSITIVE_INPUT_RANGE]) |->
        $past(positive_input_range_check_on) &&
        $past(positive_analog_input_fault))
        else $error("positive input flag rose while gated off");

    chk_negative_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        negative_analog_input_fault && negative_input_range_check_on |=>
        flag_q[`FLAG_NEGATIVE_INPUT_RANGE])
        else $error("negative input fault not flagged");

    chk_reference_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        !flag_q[`FLAG_REFERENCE_RANGE] && !reference_range_check_on |=>
        !flag_q[`FLAG_REFERENCE_RANGE])
        else $error("reference range flag set while disabled");

    chk_detect_late: assert property (
        @(posedge ref_clk) disable iff (rst)
        write_enable_reg && !flag_q[`FLAG_REFERENCE_MISSING] &&
        !reference_detect_check_on |=> !flag_q[`FLAG_REFERENCE_MISSING])
        else $error("new enable acted in the write cycle");

    chk_w1c_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        write_flag_reg && reg_wdata[`FLAG_REFERENCE_RANGE] &&
        !external_reference_input_fault |=> !flag_q[`FLAG_REFERENCE_RANGE])
        else $error("write one did not clear the flag");

    chk_set_wins: assert property (
        @(posedge ref_clk) disable iff (rst)
        write_flag_reg && positive_analog_input_fault &&
        positive_input_range_check_on |=>
        flag_q[`FLAG_POSITIVE_INPUT_RANGE])
        else $error("event lost against clear");

    chk_count_runs: assert property (
        @(posedge ref_clk) disable iff (rst)
        master_clock_counter_on |=>
        clock_count == $past(clock_count) + 16'h0001)
        else $error("clock counter did not advance");

    chk_count_holds: assert property (
        @(posedge ref_clk) disable iff (rst)
        !master_clock_counter_on [*2] |-> $stable(clock_count))
        else $error("clock counter moved while off");

endmodule

// file: common/errchk_cfg.svh
`ifndef ERRCHK_CFG_SVH
`define ERRCHK_CFG_SVH

// Register port geometry
`define REG_ADDR_W 6
`define REG_DATA_W 16

// Register addresses
`define ADDR_ERROR_ENABLE 6'h07
`define ADDR_ERROR_FLAGS 6'h06
`define ADDR_CLOCK_COUNT 6'h0a

// Enable register reset value and reserved field
`define ENABLE_RESET 16'h0040
`define ENABLE_RSV_MASK 16'he000

// Enable register bit positions
`define BIT_MASTER_CLOCK_COUNTER_ON 12
`define BIT_POSITIVE_INPUT_RANGE_CHECK_ON 11
`define BIT_NEGATIVE_INPUT_RANGE_CHECK_ON 10
`define BIT_REFERENCE_RANGE_CHECK_ON 9
`define BIT_REFERENCE_DETECT_CHECK_ON 3

// Flag register bit positions
`define FLAG_POSITIVE_INPUT_RANGE 3
`define FLAG_NEGATIVE_INPUT_RANGE 2
`define FLAG_REFERENCE_RANGE 1
`define FLAG_REFERENCE_MISSING 0
`define FLAG_COUNT 4

// Clock counter width
`define CLOCK_COUNT_W 16

`endif

// file: common/errchk_pkg.sv
package errchk_pkg;

    typedef logic [15:0] reg_word_type;
    typedef logic [5:0] reg_addr_type;
    typedef logic [3:0] flag_vec_type;

endpackage

// file: rtl/master_clock_counter.sv
`timescale 1ns/1ps
`include "errchk_cfg.svh"

module master_clock_counter
    import errchk_pkg::*;
#(
    parameter int WIDTH = `CLOCK_COUNT_W
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic count_on,
    // Count
    output logic [WIDTH-1:0] count_q
);

    logic [WIDTH-1:0] count_d;

    generate
        if (WIDTH < 1 || WIDTH > `REG_DATA_W)
        begin : g_bad_width
            $error("master_clock_counter: WIDTH must be 1 to 16");
        end
    endgenerate

    // Holds its value while off so software can read the final count
    always_comb
    begin
        count_d = count_q;
        if (count_on)
        begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

endmodule

// file: bench/host_model.sv
`timescale 1ns/1ps
`include "errchk_cfg.svh"

module host_model
    import errchk_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output reg_addr_type reg_addr,
    output reg_word_type reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [`REG_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    task automatic wr(input reg_addr_type a, input reg_word_type d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // Missing valid pulse poisons the data
    task automatic rd(input reg_addr_type a, output reg_word_type d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
`include "errchk_cfg.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
 num_errors++; $display("BAD %s exp %h got %h", n, e, s); end end

module tb_top
    import errchk_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst;
    reg_addr_type reg_addr;
    reg_word_type reg_wdata;
    logic reg_write;
    logic reg_read;
    reg_word_type reg_rdata;
    logic reg_rvalid;
    flag_vec_type flt;
    reg_word_type error_flag_enable;
    flag_vec_type error_flags;
    reg_word_type clock_count;
    reg_word_type v;
    reg_word_type c1;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    localparam int en_bit[4] = '{`BIT_REFERENCE_DETECT_CHECK_ON,
        `BIT_REFERENCE_RANGE_CHECK_ON, `BIT_NEGATIVE_INPUT_RANGE_CHECK_ON,
        `BIT_POSITIVE_INPUT_RANGE_CHECK_ON};

    host_model host_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    error_check_enable_register error_check_enable_register_inst (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .positive_analog_input_fault(flt[3]),
        .negative_analog_input_fault(flt[2]),
        .external_reference_input_fault(flt[1]),
        .external_reference_input_missing(flt[0]),
        .error_flag_enable(error_flag_enable), .error_flags(error_flags),
        .clock_count(clock_count));

    always #12.5 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic pulse(input int i);
        @(posedge ref_clk);
        flt[i] <= 1'b1;
        @(posedge ref_clk);
        flt <= 4'h0;
        @(posedge ref_clk);
        #1;
    endtask

    initial
    begin
        rst = 1'b1;
        flt = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        host_model_inst.rd(`ADDR_ERROR_ENABLE, v);
        `CHK("enable reset", 16'h0040, v)
        `CHK("flags reset", 4'h0, error_flags)
        `CHK("count reset", 16'h0000, clock_count)
        $display("test reset done");
        host_model_inst.wr(`ADDR_ERROR_ENABLE, 16'hffff);
        #1;
        `CHK("enable port", 16'h1fff, error_flag_enable)
        host_model_inst.wr(6'h3f, 16'h0000);
        host_model_inst.rd(`ADDR_ERROR_ENABLE, v);
        `CHK("enable read", 16'h1fff, v)
        host_model_inst.rd(6'h3f, v);
        `CHK("unmapped read", 16'h0000, v)
        $display("test reserved done");
        c1 = clock_count;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK("count run", c1 + 16'h000a, clock_count)
        host_model_inst.wr(`ADDR_ERROR_ENABLE, 16'h0000);
        #1;
        c1 = clock_count;
        repeat (10) @(posedge ref_clk);
        host_model_inst.rd(`ADDR_CLOCK_COUNT, v);
        `CHK("count held", c1, v)
        $display("test counter done");
        for (int i = 0; i < 4; i++)
        begin
            host_model_inst.wr(`ADDR_ERROR_ENABLE, 16'h0000);
            pulse(i);
            `CHK("flag masked", 4'h0, error_flags)
            // Fault held across the enable write must not act in its cycle
            v = 16'h0001 << en_bit[i];
            @(posedge ref_clk);
            flt[i] <= 1'b1;
            host_model_inst.wr(`ADDR_ERROR_ENABLE, v);
            #1;
            `CHK("flag late", 4'h0, error_flags)
            @(posedge ref_clk);
            flt <= 4'h0;
            #1;
            `CHK("flag set", 4'h1 << i, error_flags)
            host_model_inst.rd(`ADDR_ERROR_FLAGS, v);
            `CHK("flag read", 16'h0001 << i, v)
            host_model_inst.wr(`ADDR_ERROR_FLAGS, 16'h0000);
            #1;
            `CHK("flag kept", 4'h1 << i, error_flags)
            // A clear that meets a live fault loses to the set
            @(posedge ref_clk);
            flt[i] <= 1'b1;
            host_model_inst.wr(`ADDR_ERROR_FLAGS, 16'h0001 << i);
            #1;
            `CHK("set wins", 4'h1 << i, error_flags)
            @(posedge ref_clk);
            flt <= 4'h0;
            host_model_inst.wr(`ADDR_ERROR_FLAGS, 16'h0001 << i);
            #1;
            `CHK("flag cleared", 4'h0, error_flags)
        end
        $display("test flags done");
        end_sim();
    end
endmodule
